// [bench/stl_host_model.sv]
// Host controller model that drives the external torque limit requests
`default_nettype none
module stl_host_model (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Requests from the test sequence
  input wire logic need_fwd_in,
  input wire logic need_rev_in,
  // Discrete limit inputs of the drive
  output logic fwd_ext_limit_out,
  output logic rev_ext_limit_out
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fwd_ext_limit_out <= 1'b0;
      rev_ext_limit_out <= 1'b0;
    end else begin
      fwd_ext_limit_out <= need_fwd_in;
      rev_ext_limit_out <= need_rev_in;
    end
  end
endmodule
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the torque limiter
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic wr;
    logic [1:0] sel;
    logic [9:0] data;
    logic [9:0] mx;
    logic [1:0] ia;
    logic oa;
    logic dir;
    logic [1:0] mode;
    logic nf;
    logic nr;
    logic [9:0] cf;
    logic [9:0] cr;
    logic ff;
    logic fr;
    logic signed [15:0] trq;
  } stl_tb_in_t;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  stl_tb_in_t cur = '0;
  stl_tb_in_t nxt = '0;
  logic fwd_pin;
  logic rev_pin;
  logic signed [15:0] trq_out;
  logic clamp_act;
  logic trq_lim;
  logic [9:0] fwd_lim;
  logic [9:0] rev_lim;
  logic [9:0] set_lim [0:3];
  logic [31:0] seed = 32'h8871;
  int checks = 0;
  int mismatches = 0;
  stl_host_model stl_host_model_inst (.mclk_in(mclk_in), .rst_in(rst_in), .need_fwd_in(cur.nf),
    .need_rev_in(cur.nr), .fwd_ext_limit_out(fwd_pin), .rev_ext_limit_out(rev_pin));
  stl_torque_limiter stl_torque_limiter_inst (.mclk_in(mclk_in), .rst_in(rst_in), .param_wr_in(cur.wr),
    .param_sel_in(cur.sel), .param_data_in(cur.data), .max_torque_in(cur.mx), .input_allocation_setting_in(cur.ia),
    .output_allocation_setting_in(cur.oa), .rotation_direction_setting_in(cur.dir), .limit_mode_in(cur.mode),
    .fwd_ext_limit_in(fwd_pin), .rev_ext_limit_in(rev_pin), .cmd_fwd_torque_limit_in(cur.cf),
    .cmd_rev_torque_limit_in(cur.cr), .field_fwd_ext_limit_bit_in(cur.ff), .field_rev_ext_limit_bit_in(cur.fr),
    .torque_ref_in(cur.trq), .torque_ref_out(trq_out), .clamp_active_out(clamp_act),
    .torque_limited_out(trq_lim), .fwd_limit_out(fwd_lim), .rev_limit_out(rev_lim));
  // ****************************************
  // Expectation helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [9:0] sat(input logic [9:0] v);
    return (v > stl_pkg::LIMIT_CEIL) ? stl_pkg::LIMIT_CEIL : v;
  endfunction
  function automatic logic [9:0] eff(input logic [9:0] il, input logic [9:0] el, input logic eon,
    input logic [9:0] cl, input logic con, input logic [9:0] mx);
    logic [9:0] r;
    r = il;
    if (eon && el < r) r = el;
    if (con && sat(cl) < r) r = sat(cl);
    if (sat(mx) < r) r = sat(mx);
    return r;
  endfunction
  function automatic logic signed [15:0] clamp(input logic signed [15:0] t, input logic [9:0] p,
    input logic [9:0] n);
    if (t > $signed({6'h00, p})) return $signed({6'h00, p});
    if (t < -$signed({6'h00, n})) return -$signed({6'h00, n});
    return t;
  endfunction
  task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(posedge mclk_in);
    rst_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    rst_in <= 1'b0;
    set_lim = '{stl_pkg::INT_LIMIT_RST, stl_pkg::INT_LIMIT_RST, stl_pkg::EXT_LIMIT_RST, stl_pkg::EXT_LIMIT_RST};
  endtask
  // One cycle: predict from sampled inputs, apply next inputs, compare
  task automatic step(input logic rnd_on);
    logic [9:0] ef;
    logic [9:0] er;
    logic signed [15:0] et;
    logic pm;
    logic cm;
    logic xm;
    logic hit;
    logic lim;
    logic [95:0] r;
    @(posedge mclk_in);
    pm = (cur.mode == stl_pkg::STL_MODE_PIN);
    cm = (cur.mode == stl_pkg::STL_MODE_CMD);
    xm = (cur.mode == stl_pkg::STL_MODE_COMB);
    ef = eff(set_lim[0], set_lim[2], pm && fwd_pin && cur.ia[0], cur.cf, cm || (xm && cur.ff), cur.mx);
    er = eff(set_lim[1], set_lim[3], pm && rev_pin && cur.ia[1], cur.cr, cm || (xm && cur.fr), cur.mx);
    et = cur.dir ? clamp(cur.trq, er, ef) : clamp(cur.trq, ef, er);
    hit = (et != cur.trq);
    lim = hit && cur.oa;
    if (cur.wr) set_lim[cur.sel] = sat(cur.data);
    if (rnd_on) begin
      r = {rnd(), rnd(), rnd()};
      nxt = r[68:0];
      nxt.trq = {{5{r[10]}}, r[10:0]};
      if (nxt.mx[9:8] == 2'h2) nxt.mx = stl_pkg::LIMIT_CEIL;
    end
    cur <= nxt;
    #1;
    cmp("torque_ref_out", et, trq_out);
    cmp("fwd_limit_out", {6'h00, ef}, {6'h00, fwd_lim});
    cmp("rev_limit_out", {6'h00, er}, {6'h00, rev_lim});
    cmp("clamp_active_out", {15'h0000, hit}, {15'h0000, clamp_act});
    cmp("torque_limited_out", {15'h0000, lim}, {15'h0000, trq_lim});
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    forever #25 mclk_in = ~mclk_in;
  end
  initial begin
    repeat (100000) @(posedge mclk_in);
    mismatches++;
    end_of_test();
  end
  initial begin
    do_reset();
    // Factory limits with both requests held
    nxt.ia = 2'h3;
    nxt.oa = 1'b1;
    nxt.mx = 10'h320;
    nxt.nf = 1'b1;
    nxt.nr = 1'b1;
    nxt.trq = 16'sd500;
    repeat (3) step(1'b0);
    nxt.trq = -16'sd500;
    nxt.oa = 1'b0;
    repeat (2) step(1'b0);
    // Back-to-back writes with over-range values, except zero to the reverse internal limit
    nxt.wr = 1'b1;
    for (int i = 0; i < 4; i++) begin
      nxt.sel = i[1:0];
      nxt.data = (i == 1) ? 10'h000 : 10'h3ff;
      step(1'b0);
    end
    nxt.wr = 1'b0;
    nxt.trq = 16'sd900;
    repeat (3) step(1'b0);
    nxt.mode = stl_pkg::STL_MODE_COMB;
    nxt.ff = 1'b1;
    nxt.cf = 10'h321;
    nxt.mx = 10'h3ff;
    repeat (2) step(1'b0);
    // Reset in mid-run restores the factory limits
    do_reset();
    repeat (3) step(1'b0);
    repeat (3000) step(1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire

// [hdl/stl_lim_if.sv]
// Interface carrying one direction's limit inputs and its effective limit
`default_nettype none
interface stl_lim_if;
  logic [stl_pkg::LIM_W-1:0] internal_lim;
  logic [stl_pkg::LIM_W-1:0] external_lim;
  logic [stl_pkg::LIM_W-1:0] cmd_lim;
  logic [stl_pkg::LIM_W-1:0] max_lim;
  logic ext_on;
  logic field_on;
  stl_pkg::stl_mode_t mode;
  logic [stl_pkg::LIM_W-1:0] eff_lim;
  modport sel (input internal_lim, external_lim, cmd_lim, max_lim, ext_on, field_on, mode, output eff_lim);
  modport ctl (output internal_lim, external_lim, cmd_lim, max_lim, ext_on, field_on, mode, input eff_lim);
endinterface
`default_nettype wire

// [hdl/stl_limit_sel.sv]
// Effective limit selection for one torque direction
`default_nettype none
module stl_limit_sel (
  // Limit sources and result
  stl_lim_if.sel lim
);
  logic [stl_pkg::LIM_W-1:0] base;

  always_comb begin
    base = lim.internal_lim;
    case (lim.mode)
      // RULE_04 external pin tightens
      // RULE_05 same for reverse instance
      stl_pkg::STL_MODE_PIN: begin
        if (lim.ext_on && (lim.external_lim < base)) begin
          base = lim.external_lim;
        end
      end
      // RULE_11 host command limit
      stl_pkg::STL_MODE_CMD: begin
        if (lim.cmd_lim < base) begin
          base = lim.cmd_lim;
        end
      end
      // RULE_12 field bit selects command
      stl_pkg::STL_MODE_COMB: begin
        if (lim.field_on && (lim.cmd_lim < base)) begin
          base = lim.cmd_lim;
        end
      end
      default: begin
        base = lim.internal_lim;
      end
    endcase
    // RULE_02 motor maximum caps all
    if (base > lim.max_lim) begin
      base = lim.max_lim;
    end
    lim.eff_lim = base;
  end
endmodule
`default_nettype wire

// [hdl/stl_pkg.sv]
// Constants and types shared by the torque limiter files
`default_nettype none
package stl_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int LIM_W = 10;
  localparam int TRQ_W = 16;
  // ****************************************
  // Limit settings, percent of rated torque
  // ****************************************
  localparam logic [9:0] LIMIT_CEIL = 10'h320;
  localparam logic [9:0] INT_LIMIT_RST = 10'h320;
  localparam logic [9:0] EXT_LIMIT_RST = 10'h064;
  // ****************************************
  // Setting select codes
  // ****************************************
  localparam logic [1:0] SEL_FWD_INT = 2'h0;
  localparam logic [1:0] SEL_REV_INT = 2'h1;
  localparam logic [1:0] SEL_FWD_EXT = 2'h2;
  localparam logic [1:0] SEL_REV_EXT = 2'h3;
  // ****************************************
  // Allocation bit positions
  // ****************************************
  localparam int ALLOC_FWD_BIT = 0;
  localparam int ALLOC_REV_BIT = 1;
  // ****************************************
  // Limiting methods, Gray coded
  // ****************************************
  typedef enum logic [1:0] {
    STL_MODE_PIN = 2'h0,
    STL_MODE_CMD = 2'h1,
    STL_MODE_COMB = 2'h3
  } stl_mode_t;
endpackage
`default_nettype wire

// [hdl/stl_torque_limiter.sv]
// Torque limiter top: limit settings, selection, clamping and status
`default_nettype none
// Functional notes
// RULE_01 - Forward and reverse torque are always held within internal limits, settable 0 to 800 percent, 800 after reset.
// RULE_02 - Any limit above the motor maximum torque is replaced by that maximum.
// RULE_03 - Separate forward and reverse external limits are held, settable 0 to 800 percent, 100 after reset.
// RULE_04 - With the forward external input active the forward limit is the smaller of internal and external forward.
// RULE_05 - With the reverse external input active the reverse limit is the smaller of internal and external reverse.
// RULE_06 - The host raises an external limit input whenever it needs reduced torque.
// RULE_07 - The torque-limited status is high while the output is being clamped and low otherwise.
// RULE_08 - External limit inputs act only when assigned through the input allocation setting.
// RULE_09 - The torque-limited pin is driven only when assigned through the output allocation setting.
// RULE_10 - Direction setting 0 makes counter-clockwise (positive) torque the forward direction.
// RULE_11 - Host command forward and reverse limits are accepted as another limiting method.
// RULE_12 - A combined method lets field limit bits select the host command limits per direction.
// RULE_13 - Positive references saturate at the forward-side limit and negative ones at the negated other limit each cycle.
module stl_torque_limiter (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Limit setting writes
  input wire logic param_wr_in,
  input wire logic [1:0] param_sel_in,
  input wire logic [9:0] param_data_in,
  // Configuration
  input wire logic [9:0] max_torque_in,
  input wire logic [1:0] input_allocation_setting_in,
  input wire logic output_allocation_setting_in,
  input wire logic rotation_direction_setting_in,
  input wire logic [1:0] limit_mode_in,
  // Host controller discrete inputs
  input wire logic fwd_ext_limit_in,
  input wire logic rev_ext_limit_in,
  // Network link limits
  input wire logic [9:0] cmd_fwd_torque_limit_in,
  input wire logic [9:0] cmd_rev_torque_limit_in,
  input wire logic field_fwd_ext_limit_bit_in,
  input wire logic field_rev_ext_limit_bit_in,
  // Torque path
  input wire logic signed [15:0] torque_ref_in,
  output logic signed [15:0] torque_ref_out,
  // Status
  output logic clamp_active_out,
  output logic torque_limited_out,
  output logic [9:0] fwd_limit_out,
  output logic [9:0] rev_limit_out
);
  // ****************************************
  // Limit settings
  // ****************************************
  logic [9:0] fwd_internal_torque_limit;
  logic [9:0] rev_internal_torque_limit;
  logic [9:0] fwd_external_torque_limit;
  logic [9:0] rev_external_torque_limit;
  logic [9:0] next_fwd_int;
  logic [9:0] next_rev_int;
  logic [9:0] next_fwd_ext;
  logic [9:0] next_rev_ext;
  logic [9:0] wr_val;
  logic [9:0] max_lim;

  always_comb begin
    wr_val = (param_data_in > stl_pkg::LIMIT_CEIL) ? stl_pkg::LIMIT_CEIL : param_data_in;
    max_lim = (max_torque_in > stl_pkg::LIMIT_CEIL) ? stl_pkg::LIMIT_CEIL : max_torque_in;
    next_fwd_int = fwd_internal_torque_limit;
    next_rev_int = rev_internal_torque_limit;
    next_fwd_ext = fwd_external_torque_limit;
    next_rev_ext = rev_external_torque_limit;
    if (param_wr_in) begin
      case (param_sel_in)
        stl_pkg::SEL_FWD_INT: next_fwd_int = wr_val;
        stl_pkg::SEL_REV_INT: next_rev_int = wr_val;
        stl_pkg::SEL_FWD_EXT: next_fwd_ext = wr_val;
        stl_pkg::SEL_REV_EXT: next_rev_ext = wr_val;
        default: next_fwd_int = fwd_internal_torque_limit;
      endcase
    end
  end

  // RULE_01 internal limit defaults
  // RULE_03 external limit defaults
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fwd_internal_torque_limit <= stl_pkg::INT_LIMIT_RST;
      rev_internal_torque_limit <= stl_pkg::INT_LIMIT_RST;
      fwd_external_torque_limit <= stl_pkg::EXT_LIMIT_RST;
      rev_external_torque_limit <= stl_pkg::EXT_LIMIT_RST;
    end else begin
      fwd_internal_torque_limit <= next_fwd_int;
      rev_internal_torque_limit <= next_rev_int;
      fwd_external_torque_limit <= next_fwd_ext;
      rev_external_torque_limit <= next_rev_ext;
    end
  end

  // ****************************************
  // Effective limit selection
  // ****************************************
  stl_lim_if fwd_if ();
  stl_lim_if rev_if ();
  stl_pkg::stl_mode_t mode;
  logic [9:0] fwd_lim;
  logic [9:0] rev_lim;

  always_comb begin
    mode = stl_pkg::stl_mode_t'(limit_mode_in);
    fwd_if.internal_lim = fwd_internal_torque_limit;
    fwd_if.external_lim = fwd_external_torque_limit;
    fwd_if.cmd_lim = (cmd_fwd_torque_limit_in > stl_pkg::LIMIT_CEIL) ? stl_pkg::LIMIT_CEIL : cmd_fwd_torque_limit_in;
    fwd_if.max_lim = max_lim;
    fwd_if.field_on = field_fwd_ext_limit_bit_in;
    fwd_if.mode = mode;
    rev_if.internal_lim = rev_internal_torque_limit;
    rev_if.external_lim = rev_external_torque_limit;
    rev_if.cmd_lim = (cmd_rev_torque_limit_in > stl_pkg::LIMIT_CEIL) ? stl_pkg::LIMIT_CEIL : cmd_rev_torque_limit_in;
    rev_if.max_lim = max_lim;
    rev_if.field_on = field_rev_ext_limit_bit_in;
    rev_if.mode = mode;
    // RULE_08 pins act only when allocated
    fwd_if.ext_on = fwd_ext_limit_in & input_allocation_setting_in[stl_pkg::ALLOC_FWD_BIT];
    rev_if.ext_on = rev_ext_limit_in & input_allocation_setting_in[stl_pkg::ALLOC_REV_BIT];
  end

  // Read back outside the process above so it does not loop on its own outputs
  assign fwd_lim = fwd_if.eff_lim;
  assign rev_lim = rev_if.eff_lim;

  stl_limit_sel u_fwd_sel (
    .lim(fwd_if.sel)
  );

  stl_limit_sel u_rev_sel (
    .lim(rev_if.sel)
  );

  // ****************************************
  // Clamping and status
  // ****************************************
  logic signed [15:0] pos_lim;
  logic signed [15:0] neg_lim;
  logic signed [15:0] next_torque;
  logic next_clamp;
  logic next_limited;

  always_comb begin
    // RULE_10 direction maps forward side
    if (!rotation_direction_setting_in) begin
      pos_lim = $signed({6'h00, fwd_lim});
      neg_lim = -$signed({6'h00, rev_lim});
    end else begin
      pos_lim = $signed({6'h00, rev_lim});
      neg_lim = -$signed({6'h00, fwd_lim});
    end
    // RULE_13 per-sign saturation
    next_torque = torque_ref_in;
    next_clamp = 1'b0;
    if (torque_ref_in > pos_lim) begin
      next_torque = pos_lim;
      next_clamp = 1'b1;
    end else if (torque_ref_in < neg_lim) begin
      next_torque = neg_lim;
      next_clamp = 1'b1;
    end
    // RULE_09 pin needs allocation
    next_limited = next_clamp & output_allocation_setting_in;
  end

  // RULE_07 status follows clamping
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      torque_ref_out <= 16'sh0000;
      clamp_active_out <= 1'b0;
      torque_limited_out <= 1'b0;
      fwd_limit_out <= 10'h000;
      rev_limit_out <= 10'h000;
    end else begin
      torque_ref_out <= next_torque;
      clamp_active_out <= next_clamp;
      torque_limited_out <= next_limited;
      fwd_limit_out <= fwd_lim;
      rev_limit_out <= rev_lim;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_pos_bound: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_13
    1'b1 |=> (torque_ref_out <= $past(pos_lim)) && (torque_ref_out >= $past(neg_lim)))
    else $error("torque output outside effective limits");

  a_pass_through: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_13
    (torque_ref_in <= pos_lim && torque_ref_in >= neg_lim) |=> torque_ref_out == $past(torque_ref_in))
    else $error("unclamped reference altered");

  a_max_cap: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_02
    fwd_lim <= max_lim && rev_lim <= max_lim)
    else $error("limit above motor maximum");

  a_internal_cap: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_01
    fwd_lim <= fwd_internal_torque_limit && rev_lim <= rev_internal_torque_limit && fwd_lim <= stl_pkg::LIMIT_CEIL)
    else $error("limit above internal limit");

  a_fwd_external: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_04
    (mode == stl_pkg::STL_MODE_PIN && fwd_if.ext_on) |-> fwd_lim <= fwd_external_torque_limit)
    else $error("forward external limit not applied");

  a_rev_external: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_05
    (mode == stl_pkg::STL_MODE_PIN && rev_if.ext_on) |-> rev_lim <= rev_external_torque_limit)
    else $error("reverse external limit not applied");

  a_unalloc_ignored: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_08
    (mode == stl_pkg::STL_MODE_PIN && !input_allocation_setting_in[stl_pkg::ALLOC_FWD_BIT])
    |-> fwd_lim == ((fwd_internal_torque_limit > max_lim) ? max_lim : fwd_internal_torque_limit))
    else $error("unallocated input changed limit");

  a_clamp_flag: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_07
    1'b1 |=> clamp_active_out == (torque_ref_out != $past(torque_ref_in)))
    else $error("clamp status disagrees with output");

  a_status_pin: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_09
    !output_allocation_setting_in |=> !torque_limited_out)
    else $error("status pin driven while unallocated");

  a_dir_map: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_10
    (!rotation_direction_setting_in && torque_ref_in > 16'sh0000)
    |=> torque_ref_out <= $signed({6'h00, fwd_limit_out}))
    else $error("forward limit not on positive side");

  a_cmd_limit: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_11
    mode == stl_pkg::STL_MODE_CMD |-> fwd_lim <= cmd_fwd_torque_limit_in && rev_lim <= cmd_rev_torque_limit_in)
    else $error("command limit not applied");

  a_comb_limit: assert property (@(posedge mclk_in) disable iff (rst_in) // RULE_12
    (mode == stl_pkg::STL_MODE_COMB && field_fwd_ext_limit_bit_in) |-> fwd_lim <= cmd_fwd_torque_limit_in)
    else $error("combined mode command limit not applied");

  a_setting_default: assert property (@(posedge mclk_in) // RULE_03
    $fell(rst_in) |-> fwd_external_torque_limit == stl_pkg::EXT_LIMIT_RST)
    else $error("external limit default wrong");
endmodule
`default_nettype wire
